// ### hdl/rafw_pkg.sv
/*
  codes, field positions, timing, register map and carriers.
  assumes a 10 MHz clock and a byte deframer.
*/
package rafw_pkg;

  // ----------------------------------------------------------------
  // command, flag and error codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_WR_AFI = 8'h27;
  localparam logic [7:0] CMD_LK_AFI = 8'h28;
  localparam logic [7:0] CMD_WR_DSF = 8'h29;
  localparam logic [7:0] CMD_LK_DSF = 8'h2a;
  localparam logic [7:0] ERR_RELOCK = 8'h11;
  localparam logic [7:0] ERR_LOCKED = 8'h12;
  localparam logic [7:0] ERR_PROG   = 8'h13;
  localparam logic [7:0] ERR_LOCK   = 8'h14;
  localparam logic [7:0] RSP_OK     = 8'h00;
  localparam logic [7:0] RSP_ERR    = 8'h01;
  localparam int         FLG_ADDR   = 5;
  localparam int         FLG_OPT    = 6;

  // ----------------------------------------------------------------
  // request layout, byte counts including the two crc bytes
  // ----------------------------------------------------------------
  localparam logic [3:0] BI_FLAGS = 4'd0;
  localparam logic [3:0] BI_CMD   = 4'd1;
  localparam logic [3:0] BI_UID0  = 4'd2;
  localparam logic [3:0] LEN_BASE = 4'd4;
  localparam logic [3:0] LEN_UID  = 4'd8;
  localparam logic [3:0] LEN_VAL  = 4'd1;

  // ----------------------------------------------------------------
  // program cycle timing
  // ----------------------------------------------------------------
  localparam int CLK_NS    = 100;
  localparam int NOMINAL_REPLY_DELAY_NS  = 320_900;
  localparam int SLOT_NS   = 302_000;
  localparam int SLOT_N    = 18;
  localparam int WT_NS     = NOMINAL_REPLY_DELAY_NS + SLOT_N * SLOT_NS;
  localparam int WT_CYC    = WT_NS / CLK_NS;
  typedef logic [16:0] rafw_tmr_t;

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MASK   = 8'h08;
  localparam logic [7:0] ADDR_IDVAL  = 8'h0c;
  localparam int         CTRL_WIP    = 0;
  localparam int         EV_OK       = 0;
  localparam int         EV_ERR      = 1;
  localparam int         ID_AFI_LSB  = 0;
  localparam int         ID_DSF_LSB  = 8;
  localparam int         ID_AFI_LK   = 16;
  localparam int         ID_DSF_LK   = 17;
  localparam int         ID_BUSY     = 18;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum {ST_IDLE, ST_RX, ST_PROG, ST_OPT_EOF, ST_RESP, ST_TXWAIT} rafw_state_e;

  typedef struct packed {
    logic       sof;
    logic       vld;
    logic [7:0] data;
    logic       eof;
    logic       crc_ok;
  } rafw_rx_s;

  typedef struct packed {
    logic       vld;
    logic [7:0] data;
    logic       last;
  } rafw_tx_s;

endpackage : rafw_pkg

// ### hdl/rafw_top.sv
/*
  identifier write / lock handler with timed cycle, status pin, AXI4-Lite.
  assumes a crc-checking deframer and a crc-adding transmitter on aclk.
*/
`timescale 1ns/1ps
module rafw_top #(
  parameter int WT_CYCLES = rafw_pkg::WT_CYC
) (
  // clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // axi4-lite slave
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // request bytes from the deframer
  input  wire rafw_pkg::rafw_rx_s rx,
  input  wire logic [63:0]        own_uid,
  // answer bytes to the transmitter
  output rafw_pkg::rafw_tx_s      tx,
  input  wire logic               tx_ready,
  input  wire logic               tx_done,
  // nonvolatile cell outcome at end of cycle
  input  wire logic               nvm_fault,
  // status pin, open drain, and interrupt
  output logic                    rf_activity_status_pin_o,
  output logic                    rf_activity_status_pin_oe,
  output logic                    irq
);

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic is_write(input logic [7:0] c);
    is_write = (c == rafw_pkg::CMD_WR_AFI) || (c == rafw_pkg::CMD_WR_DSF);
  endfunction : is_write

  function automatic logic is_ours(input logic [7:0] c);
    is_ours = is_write(c) || (c == rafw_pkg::CMD_LK_AFI) || (c == rafw_pkg::CMD_LK_DSF);
  endfunction : is_ours

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  rafw_pkg::rafw_state_e st_q;
  rafw_pkg::rafw_tmr_t   tmr_q;
  logic [3:0]            cnt_q;
  logic [7:0]            flags_q, cmd_q, val_q, err_q;
  logic [63:0]           uid_q;
  logic                  is_err_q, hdr_sent_q;
  logic [7:0]            afi_q, dsf_q;
  logic                  afi_lk_q, dsf_lk_q;
  logic                  mode_wip_q;
  logic [1:0]            status_q, mask_q;

  // ----------------------------------------------------------------
  // request check at eof
  // ----------------------------------------------------------------
  wire       addr_mode = flags_q[rafw_pkg::FLG_ADDR];
  wire       opt_mode  = flags_q[rafw_pkg::FLG_OPT];
  wire       tgt_dsf   = (cmd_q == rafw_pkg::CMD_WR_DSF) || (cmd_q == rafw_pkg::CMD_LK_DSF);
  wire       cmd_wr    = is_write(cmd_q);
  wire [3:0] val_idx   = addr_mode ? rafw_pkg::BI_UID0 + rafw_pkg::LEN_UID : rafw_pkg::BI_UID0;
  wire [3:0] exp_len   = rafw_pkg::LEN_BASE + (addr_mode ? rafw_pkg::LEN_UID : 4'd0)
                         + (cmd_wr ? rafw_pkg::LEN_VAL : 4'd0);
  wire       req_ok    = rx.crc_ok && (cnt_q == exp_len) && (!addr_mode || uid_q == own_uid);
  wire       tgt_lk    = tgt_dsf ? dsf_lk_q : afi_lk_q;
  wire       cyc_end   = (tmr_q == '0);
  wire       commit    = (st_q == rafw_pkg::ST_PROG) && cyc_end && !nvm_fault;
  wire       pre_err   = (st_q == rafw_pkg::ST_RX) && rx.eof && req_ok && tgt_lk;
  wire       prog_err  = (st_q == rafw_pkg::ST_PROG) && cyc_end && nvm_fault;
  wire       tx_take   = tx.vld && tx_ready;

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= rafw_pkg::ST_IDLE;
      tmr_q <= '0;
      cnt_q <= '0;
    end else begin
      unique case (st_q)
        rafw_pkg::ST_IDLE: if (rx.sof) begin
          st_q <= rafw_pkg::ST_RX;
          cnt_q <= '0;
        end
        rafw_pkg::ST_RX: begin
          if (rx.sof) begin
            cnt_q <= '0;
          end else if (rx.vld) begin
            cnt_q <= (cnt_q == 4'hf) ? cnt_q : cnt_q + 4'd1;
            // foreign commands are left to their own handlers
            if (cnt_q == rafw_pkg::BI_CMD && !is_ours(rx.data)) st_q <= rafw_pkg::ST_IDLE;
          end else if (rx.eof) begin
            if (!req_ok) st_q <= rafw_pkg::ST_IDLE;
            else if (tgt_lk) st_q <= rafw_pkg::ST_RESP;
            else begin
              st_q <= rafw_pkg::ST_PROG;
              tmr_q <= rafw_pkg::rafw_tmr_t'(WT_CYCLES - 1);
            end
          end
        end
        rafw_pkg::ST_PROG: begin
          if (!cyc_end) tmr_q <= tmr_q - 1'b1;
          else st_q <= opt_mode ? rafw_pkg::ST_OPT_EOF : rafw_pkg::ST_RESP;
        end
        rafw_pkg::ST_OPT_EOF: if (rx.eof) st_q <= rafw_pkg::ST_RESP;
        rafw_pkg::ST_RESP: if (tx_take && tx.last) st_q <= rafw_pkg::ST_TXWAIT;
        rafw_pkg::ST_TXWAIT: if (tx_done) st_q <= rafw_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // request field capture
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= '0;
      cmd_q <= '0;
      val_q <= '0;
      uid_q <= '0;
    end else if (st_q == rafw_pkg::ST_RX && rx.vld && !rx.sof) begin
      if (cnt_q == rafw_pkg::BI_FLAGS) flags_q <= rx.data;
      if (cnt_q == rafw_pkg::BI_CMD) cmd_q <= rx.data;
      if (addr_mode && cnt_q >= rafw_pkg::BI_UID0 && cnt_q < val_idx) uid_q <= {rx.data, uid_q[63:8]};
      if (cmd_wr && cnt_q == val_idx) val_q <= rx.data;
    end
  end

  // ----------------------------------------------------------------
  // outcome and stored identifiers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      is_err_q <= 1'b0;
      err_q <= '0;
    end else if (pre_err) begin
      is_err_q <= 1'b1;
      err_q <= cmd_wr ? rafw_pkg::ERR_LOCKED : rafw_pkg::ERR_RELOCK;
    end else if (prog_err) begin
      is_err_q <= 1'b1;
      err_q <= cmd_wr ? rafw_pkg::ERR_PROG : rafw_pkg::ERR_LOCK;
    end else if (st_q == rafw_pkg::ST_RX && rx.eof) begin
      is_err_q <= 1'b0;
    end
  end

  // values change only after a clean cycle, so a failed cycle keeps the old ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      afi_q <= '0;
      dsf_q <= '0;
      afi_lk_q <= 1'b0;
      dsf_lk_q <= 1'b0;
    end else if (commit) begin
      if (cmd_q == rafw_pkg::CMD_WR_AFI) afi_q <= val_q;
      if (cmd_q == rafw_pkg::CMD_LK_AFI) afi_lk_q <= 1'b1;
      if (cmd_q == rafw_pkg::CMD_WR_DSF) dsf_q <= val_q;
      if (cmd_q == rafw_pkg::CMD_LK_DSF) dsf_lk_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // answer bytes: flags, then the code only on error
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx <= '0;
      hdr_sent_q <= 1'b0;
    end else if (st_q != rafw_pkg::ST_RESP) begin
      tx <= '0;
      hdr_sent_q <= 1'b0;
    end else if (!tx.vld) begin
      if (!hdr_sent_q) begin
        tx.vld <= 1'b1;
        tx.data <= is_err_q ? rafw_pkg::RSP_ERR : rafw_pkg::RSP_OK;
        tx.last <= !is_err_q;
      end
    end else if (tx_ready) begin
      hdr_sent_q <= 1'b1;
      tx.vld <= !tx.last;
      tx.data <= err_q;
      tx.last <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // status pin, open drain: only low or released
  // ----------------------------------------------------------------
  wire busy_win = (st_q != rafw_pkg::ST_IDLE);
  wire wip_win  = (st_q == rafw_pkg::ST_PROG) || (st_q == rafw_pkg::ST_OPT_EOF);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rf_activity_status_pin_o <= 1'b0;
      rf_activity_status_pin_oe <= 1'b0;
    end else begin
      rf_activity_status_pin_o <= 1'b0;
      rf_activity_status_pin_oe <= mode_wip_q ? wip_win : busy_win;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  logic       aw_full_q, w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  wire        aw_hs    = s_axi_awvalid && s_axi_awready;
  wire        w_hs     = s_axi_wvalid && s_axi_wready;
  wire        b_hs     = s_axi_bvalid && s_axi_bready;
  wire        wr_fire  = aw_full_q && w_full_q && !s_axi_bvalid;
  wire        wr_map   = aw_addr_q == rafw_pkg::ADDR_CTRL || aw_addr_q == rafw_pkg::ADDR_STATUS
                         || aw_addr_q == rafw_pkg::ADDR_MASK || aw_addr_q == rafw_pkg::ADDR_IDVAL;
  wire        wr_lane0 = wr_fire && w_strb_q[0];
  wire        aw_full_d = (aw_full_q || aw_hs) && !wr_fire;
  wire        w_full_d  = (w_full_q || w_hs) && !wr_fire;
  wire        bvalid_d  = (s_axi_bvalid && !b_hs) || wr_fire;

  // address and data taken in either order, answer once both are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= rafw_pkg::RESP_OKAY;
    end else begin
      if (aw_hs) aw_addr_q <= s_axi_awaddr;
      if (w_hs) w_data_q <= s_axi_wdata;
      if (w_hs) w_strb_q <= s_axi_wstrb;
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      s_axi_awready <= !aw_full_d && !bvalid_d;
      s_axi_wready <= !w_full_d && !bvalid_d;
      s_axi_bvalid <= bvalid_d;
      if (wr_fire) s_axi_bresp <= wr_map ? rafw_pkg::RESP_OKAY : rafw_pkg::RESP_SLVERR;
    end
  end

  // ----------------------------------------------------------------
  // control, event and mask registers
  // ----------------------------------------------------------------
  wire [1:0] ev_set = {pre_err || prog_err, commit};
  wire [1:0] ev_clr = (wr_lane0 && aw_addr_q == rafw_pkg::ADDR_STATUS) ? w_data_q[1:0] : 2'b00;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_wip_q <= 1'b0;
      mask_q <= '0;
      status_q <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_lane0 && aw_addr_q == rafw_pkg::ADDR_CTRL) mode_wip_q <= w_data_q[rafw_pkg::CTRL_WIP];
      if (wr_lane0 && aw_addr_q == rafw_pkg::ADDR_MASK) mask_q <= w_data_q[1:0];
      // a new event beats a clear in the same cycle
      status_q <= (status_q & ~ev_clr) | ev_set;
      irq <= |(((status_q & ~ev_clr) | ev_set) & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_word;
  logic        rd_map;
  always_comb begin
    rd_word = '0;
    rd_map = 1'b1;
    unique case (s_axi_araddr)
      rafw_pkg::ADDR_CTRL:   rd_word[rafw_pkg::CTRL_WIP] = mode_wip_q;
      rafw_pkg::ADDR_STATUS: rd_word[1:0] = status_q;
      rafw_pkg::ADDR_MASK:   rd_word[1:0] = mask_q;
      rafw_pkg::ADDR_IDVAL: begin
        rd_word[rafw_pkg::ID_AFI_LSB +: 8] = afi_q;
        rd_word[rafw_pkg::ID_DSF_LSB +: 8] = dsf_q;
        rd_word[rafw_pkg::ID_AFI_LK] = afi_lk_q;
        rd_word[rafw_pkg::ID_DSF_LK] = dsf_lk_q;
        rd_word[rafw_pkg::ID_BUSY] = busy_win;
      end
      default: rd_map = 1'b0;
    endcase
  end

  // one read in flight; arready drops while the data waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= rafw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_map ? rafw_pkg::RESP_OKAY : rafw_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule : rafw_top

// ### verification/rafw_props.sv
/*
  port checker of the identifier handler.
  assumes a bind into rafw_top.
*/
`timescale 1ns/1ps
module rafw_props #(
  parameter int WT_CYCLES = rafw_pkg::WT_CYC
) (
  // clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // axi4-lite
  input wire logic [7:0]         s_axi_awaddr,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic [31:0]        s_axi_wdata,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic               s_axi_rvalid,
  // rf streams and pin
  input wire rafw_pkg::rafw_rx_s rx,
  input wire rafw_pkg::rafw_tx_s tx,
  input wire logic               tx_ready,
  input wire logic               tx_done,
  input wire logic               rf_activity_status_pin_o,
  input wire logic               rf_activity_status_pin_oe
);
  logic wip_q;
  // ----------------------------------------------------------------
  // pin mode copy; needs aw and w taken together
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wip_q <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready &&
                 s_axi_awaddr == rafw_pkg::ADDR_CTRL) begin
      wip_q <= s_axi_wdata[rafw_pkg::CTRL_WIP];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("b dropped");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("b late");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("r late");
  a_tx_hold: assert property (tx.vld && !tx_ready |=> tx.vld && $stable(tx.data) && $stable(tx.last))
    else $error("tx not held");
  a_ok_alone: assert property (tx.vld && tx.data == rafw_pkg::RSP_OK |-> tx.last)
    else $error("ok not alone");
  a_err_code: assert property (tx.vld && tx_ready && tx.data == rafw_pkg::RSP_ERR |-> !tx.last ##[1:8]
    (tx.vld && tx.last && tx.data >= rafw_pkg::ERR_RELOCK && tx.data <= rafw_pkg::ERR_LOCK))
    else $error("no error code");
  a_pin_low: assert property (rf_activity_status_pin_o == 1'b0)
    else $error("pin high");
  a_busy_sof: assert property (!wip_q && rx.sof |-> ##[1:3] rf_activity_status_pin_oe)
    else $error("busy pin late");
  a_busy_tx: assert property (!wip_q && tx.vld |-> rf_activity_status_pin_oe)
    else $error("busy pin off in answer");
  a_wip_sof: assert property (wip_q && rx.sof |-> (!rf_activity_status_pin_oe) [*3])
    else $error("wip pin in request");
  a_wip_end: assert property (wip_q && tx_done |=> !rf_activity_status_pin_oe)
    else $error("wip pin after answer");
endmodule : rafw_props

bind rafw_top rafw_props #(.WT_CYCLES(WT_CYCLES)) u_props (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .rx(rx), .tx(tx), .tx_ready(tx_ready), .tx_done(tx_done),
  .rf_activity_status_pin_o(rf_activity_status_pin_o), .rf_activity_status_pin_oe(rf_activity_status_pin_oe)
);

// ### verification/rafw_reader.sv
/*
  reader model: sends requests, takes answers.
  assumes calls right after a rising edge.
*/
`timescale 1ns/1ps
module rafw_reader (
  // clock
  input  wire logic               aclk,
  // request stream
  output rafw_pkg::rafw_rx_s      rx,
  // answer stream
  input  wire rafw_pkg::rafw_tx_s tx,
  output logic                    tx_ready,
  output logic                    tx_done
);
  logic [7:0] ans_q[$];
  logic [1:0] stall_q = 2'b00;
  bit         slow = 1'b0;
  int         cyc = 0;
  int         ndone = 0;
  int         eof_cyc;
  int         first_cyc;
  // idle stream until the first frame
  initial begin
    rx       = '0;
    tx_ready = 1'b0;
    tx_done  = 1'b0;
  end
  // whole frame; idle data is the inverse
  task automatic send(input logic [7:0] b[$], input logic ok);
    @(posedge aclk);
    rx.sof <= 1'b1;
    foreach (b[i]) begin
      @(posedge aclk);
      rx.sof  <= 1'b0;
      rx.vld  <= 1'b1;
      rx.data <= b[i];
    end
    @(posedge aclk);
    rx.vld    <= 1'b0;
    rx.data   <= ~b[b.size()-1];
    rx.eof    <= 1'b1;
    rx.crc_ok <= ok;
    @(posedge aclk);
    rx.eof    <= 1'b0;
    rx.crc_ok <= 1'b0;
    eof_cyc = cyc;
  endtask : send
  // lone eof, after the write cycle
  task automatic eof_only();
    rx.eof    <= 1'b1;
    rx.crc_ok <= 1'b1;
    @(posedge aclk);
    rx.eof    <= 1'b0;
    rx.crc_ok <= 1'b0;
  endtask : eof_only
  // answer side; slow takes one edge in four
  always @(posedge aclk) begin
    cyc = cyc + 1;
    tx_done <= 1'b0;
    if (tx.vld && tx_ready) begin
      if (ans_q.size() == 0) first_cyc = cyc;
      ans_q.push_back(tx.data);
      if (tx.last) begin
        tx_done <= 1'b1;
        ndone = ndone + 1;
      end
    end
    stall_q  <= stall_q + 2'd1;
    tx_ready <= !slow || stall_q == 2'b11;
  end
endmodule : rafw_reader

// ### verification/tb_top.sv
/*
  bench of the identifier handler.
  assumes the reader model; cycle cut to WT.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int          WT  = 20;
  localparam logic [63:0] UID = 64'h0123_4567_89ab_cdef;
  logic               aclk, aresetn, awready, wready, bvalid, arready, rvalid, irq, oe, pin_o;
  logic               awvalid, wvalid, bready, arvalid, rready, nvm_fault, tx_ready, tx_done, pin_mid;
  logic [7:0]         awaddr, araddr;
  logic [31:0]        wdata, rdata, rd;
  logic [1:0]         bresp, rresp, rr;
  rafw_pkg::rafw_rx_s rx;
  rafw_pkg::rafw_tx_s tx;
  logic [7:0]         req[$];
  int                 dur, err_count, num_checks;
  rafw_top #(.WT_CYCLES(WT)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .rx(rx), .own_uid(UID), .tx(tx), .tx_ready(tx_ready), .tx_done(tx_done),
    .nvm_fault(nvm_fault), .rf_activity_status_pin_o(pin_o), .rf_activity_status_pin_oe(oe), .irq(irq));
  rafw_reader u_rdr (.aclk(aclk), .rx(rx), .tx(tx), .tx_ready(tx_ready), .tx_done(tx_done));
  // 100 ns clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // each channel dropped at its taking edge; bready, rready stay high
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rr = bresp;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rr = rresp;
  endtask : axr
  // request bytes, uid lsb first
  task automatic mk(input logic [7:0] fl, cmd, val, input logic [63:0] uid);
    req = {fl, cmd};
    if (fl[rafw_pkg::FLG_ADDR]) for (int i = 0; i < 8; i++) req.push_back(uid[8*i +: 8]);
    if (cmd == rafw_pkg::CMD_WR_AFI || cmd == rafw_pkg::CMD_WR_DSF) req.push_back(val);
    req.push_back(8'h5d);
    req.push_back(8'hd5);
  endtask : mk
  // one command; pin seen mid cycle
  task automatic rfc(input logic [7:0] fl, cmd, val, input logic flt);
    int k;
    mk(fl, cmd, val, UID);
    nvm_fault <= flt;
    u_rdr.ans_q.delete();
    k = u_rdr.ndone;
    u_rdr.send(req, 1'b1);
    repeat (WT / 2) @(posedge aclk);
    @(negedge aclk);
    pin_mid = oe;
    repeat (WT) @(posedge aclk);
    if (fl[rafw_pkg::FLG_OPT]) begin
      chk(u_rdr.ans_q.size(), 0);
      u_rdr.eof_only();
    end
    for (int n = 0; n < 8 * WT && u_rdr.ndone == k; n++) @(posedge aclk);
    dur = u_rdr.first_cyc - u_rdr.eof_cyc;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
    chk(oe, 1'b0);
    @(posedge aclk);
  endtask : rfc
  task automatic rsp(input logic [7:0] e0, e1);
    chk(u_rdr.ans_q.size(), (e0 == rafw_pkg::RSP_OK) ? 1 : 2);
    chk(u_rdr.ans_q[0], e0);
    if (e0 != rafw_pkg::RSP_OK) chk(u_rdr.ans_q[1], e1);
  endtask : rsp
  task automatic t_regs();
    logic [7:0] am[4] = '{rafw_pkg::ADDR_CTRL, rafw_pkg::ADDR_STATUS, rafw_pkg::ADDR_MASK, rafw_pkg::ADDR_IDVAL};
    foreach (am[i]) begin
      axr(am[i]);
      chk(rd, 0);
      chk(rr, rafw_pkg::RESP_OKAY);
    end
    axr(8'h10);
    chk({rd, rr}, {32'h0, rafw_pkg::RESP_SLVERR});
    axw(8'h10, 32'hffff_ffff);
    chk(rr, rafw_pkg::RESP_SLVERR);
    axw(rafw_pkg::ADDR_IDVAL, 32'hffff_ffff);
    axr(rafw_pkg::ADDR_IDVAL);
    chk(rd, 0);
  endtask : t_regs
  task automatic t_afi_busy();
    axw(rafw_pkg::ADDR_MASK, 32'h1);
    rfc(8'h02, rafw_pkg::CMD_WR_AFI, 8'h5a, 1'b0);
    rsp(rafw_pkg::RSP_OK, 8'h00);
    chk(pin_mid, 1'b1);
    chk(dur >= WT && dur <= WT + 6, 1'b1);
    axr(rafw_pkg::ADDR_IDVAL);
    chk(rd[7:0], 8'h5a);
    chk({irq, rd[rafw_pkg::ID_AFI_LK]}, 2'b10);
    axw(rafw_pkg::ADDR_STATUS, 32'h1);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b0);
  endtask : t_afi_busy
  task automatic t_dsf_wip();
    axw(rafw_pkg::ADDR_CTRL, 32'h1);
    rfc(8'h22, rafw_pkg::CMD_WR_DSF, 8'ha5, 1'b0);
    rsp(rafw_pkg::RSP_OK, 8'h00);
    chk(pin_mid, 1'b1);
    axr(rafw_pkg::ADDR_IDVAL);
    chk(rd[15:0], 16'ha55a);
  endtask : t_dsf_wip
  task automatic t_lock_afi();
    axw(rafw_pkg::ADDR_CTRL, 32'h0);
    u_rdr.slow = 1'b1;
    rfc(8'h02, rafw_pkg::CMD_LK_AFI, 8'h00, 1'b0);
    rsp(rafw_pkg::RSP_OK, 8'h00);
    rfc(8'h02, rafw_pkg::CMD_LK_AFI, 8'h00, 1'b0);
    rsp(rafw_pkg::RSP_ERR, rafw_pkg::ERR_RELOCK);
    rfc(8'h02, rafw_pkg::CMD_WR_AFI, 8'h77, 1'b0);
    rsp(rafw_pkg::RSP_ERR, rafw_pkg::ERR_LOCKED);
    axr(rafw_pkg::ADDR_IDVAL);
    chk({rd[rafw_pkg::ID_AFI_LK], rd[7:0]}, 9'h15a);
    u_rdr.slow = 1'b0;
  endtask : t_lock_afi
  task automatic t_faults();
    axw(rafw_pkg::ADDR_STATUS, 32'h3);
    rfc(8'h02, rafw_pkg::CMD_WR_DSF, 8'h33, 1'b1);
    rsp(rafw_pkg::RSP_ERR, rafw_pkg::ERR_PROG);
    chk(irq, 1'b0);
    rfc(8'h02, rafw_pkg::CMD_LK_DSF, 8'h00, 1'b1);
    rsp(rafw_pkg::RSP_ERR, rafw_pkg::ERR_LOCK);
    axr(rafw_pkg::ADDR_IDVAL);
    chk({rd[rafw_pkg::ID_DSF_LK], rd[15:8]}, 9'h0a5);
    axw(rafw_pkg::ADDR_MASK, 32'h3);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    axw(rafw_pkg::ADDR_STATUS, 32'h3);
  endtask : t_faults
  task automatic t_option();
    rfc(8'h42, rafw_pkg::CMD_LK_DSF, 8'h00, 1'b0);
    rsp(rafw_pkg::RSP_OK, 8'h00);
    rfc(8'h02, rafw_pkg::CMD_WR_DSF, 8'h11, 1'b0);
    rsp(rafw_pkg::RSP_ERR, rafw_pkg::ERR_LOCKED);
    axr(rafw_pkg::ADDR_IDVAL);
    chk({rd[rafw_pkg::ID_DSF_LK], rd[15:8]}, 9'h1a5);
  endtask : t_option
  // bad crc, foreign uid: no answer
  task automatic t_refuse();
    u_rdr.ans_q.delete();
    mk(8'h02, rafw_pkg::CMD_LK_AFI, 8'h00, UID);
    u_rdr.send(req, 1'b0);
    mk(8'h22, rafw_pkg::CMD_WR_DSF, 8'h99, ~UID);
    u_rdr.send(req, 1'b1);
    repeat (2 * WT) @(posedge aclk);
    chk({u_rdr.ans_q.size(), oe}, 0);
  endtask : t_refuse
  task automatic results();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  // watchdog, far past the run
  initial begin
    repeat (20000) @(posedge aclk);
    err_count++;
    results();
  end
  initial begin
    {aresetn, awvalid, wvalid, arvalid, nvm_fault} = '0;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata} = '0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_afi_busy();
    t_dsf_wip();
    t_lock_afi();
    t_faults();
    t_option();
    t_refuse();
    results();
  end
endmodule : tb_top
